// >>> design/core_mem_pkg.sv
// constants, timing figures and register map of the core memory cycle control
//
// Summary of operation
// [RULE1] load 12 address lines at cycle start
// [RULE2] central control raises write level with start
// [RULE3] central control shows clock normal or stepping
// [RULE4] write start copies 48 data bits, sets write flag
// [RULE5] only bits 1-48 cross; parity stays inside
// [RULE6] pulse counter steps 0..3 on system clock
// [RULE7] start on first pulse triggers switch timer
// [RULE8] phase chain runs on without system clock
// [RULE9] read phase destructively reads addressed word always; code clears it only when the strobe falls inside the read phase
// [RULE10] write strobe sets parity bit for odd parity
// [RULE11] read strobe loads all sensed bits
// [RULE12] read leaves info register and write flag clear
// [RULE13] even ones on read set error at third pulse
// [RULE14] second write pulse only advances counter
// [RULE15] read end, gap, then inhibit starts write phase
// [RULE16] inhibit drivers energised for zero bits
// [RULE17] counter three drives cycle done low
// [RULE18] central control clears its flops at fourth pulse
// [RULE19] inhibit end fires clear of registers
// [RULE20] read-only levels quiet on writes
// [RULE21] central control grants, then sends start
// [RULE22] read obtained levels true at count one
// [RULE23] read gate level true at count two
// [RULE24] count three clears error, returns to zero
// [RULE25] phase lengths are programmable cycle counts
// [RULE26] strobe at fixed count; parity checked after
package core_mem_pkg;
	localparam int CLK_MHZ   = 40;
	localparam int NS_PER_US = 1000;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 48;
	localparam int WORD_W    = 49;
	localparam int WORDS     = 4096;
	localparam int AV_ADDR_W = 6;
	localparam int AV_DATA_W = 32;
	localparam int AV_BE_W   = 4;
	localparam int BYTE_W    = 8;
	localparam int CNT_W     = 16;
	localparam int SYNC_W    = 4 + ADDR_W + DATA_W;

	// pulse counter values
	localparam logic [1:0] PC_ZERO  = 2'h0;
	localparam logic [1:0] PC_ONE   = 2'h1;
	localparam logic [1:0] PC_TWO   = 2'h2;
	localparam logic [1:0] PC_THREE = 2'h3;

	// nominal phase lengths in ns
	localparam int READ_NS   = 1000;
	localparam int GAP_NS    = 300;
	localparam int INH_NS    = 1550;
	localparam int WRITE_NS  = 1000;
	localparam int STROBE_NS = 630;
	localparam int CLEAR_NS  = 100;

	// least time rounds up to whole fast-clock cycles
	function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
		return CNT_W'((ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	endfunction

	// timing configuration slots
	localparam int NUM_CFG    = 6;
	localparam int CFG_READ   = 0;
	localparam int CFG_GAP    = 1;
	localparam int CFG_INH    = 2;
	localparam int CFG_WRITE  = 3;
	localparam int CFG_STROBE = 4;
	localparam int CFG_CLEAR  = 5;
	localparam logic [CNT_W-1:0] CFG_RESET [NUM_CFG] = '{
		ns_to_cyc(READ_NS), ns_to_cyc(GAP_NS), ns_to_cyc(INH_NS),
		ns_to_cyc(WRITE_NS), ns_to_cyc(STROBE_NS), ns_to_cyc(CLEAR_NS)};

	// register byte offsets
	localparam logic [AV_ADDR_W-1:0] REG_STATUS      = 6'h00;
	localparam logic [AV_ADDR_W-1:0] REG_CFG_BASE    = 6'h04;
	localparam logic [AV_ADDR_W-1:0] REG_ERR_COUNT   = 6'h1c;
	localparam logic [AV_ADDR_W-1:0] REG_CYCLE_COUNT = 6'h20;
	localparam logic [AV_ADDR_W-1:0] REG_STRIDE      = 6'h04;

	// status field positions
	localparam int ST_PCNT_LSB  = 0;
	localparam int ST_PHASE_LSB = 4;
	localparam int ST_WRITE_BIT = 8;
	localparam int ST_ERR_BIT   = 9;
	localparam int ST_BUSY_BIT  = 10;

	// sync vector bit positions
	localparam int SY_PULSE  = SYNC_W - 1;
	localparam int SY_START  = SYNC_W - 2;
	localparam int SY_WRITE  = SYNC_W - 3;
	localparam int SY_NORM_N = SYNC_W - 4;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_READ,
		PH_GAP,
		PH_INHIBIT,
		PH_CLEAR
	} phase_type;
endpackage

// >>> design/core_stack.sv
// storage array of 49-bit words with destructive read and inhibit-driven write
`timescale 1ns/1ps
module core_stack
	import core_mem_pkg::*;
(
	input  wire logic                        i_clk_sys,
	input  wire logic [core_mem_pkg::ADDR_W-1:0] i_addr,
	input  wire logic                        i_read_drive,
	input  wire logic                        i_sense,
	input  wire logic                        i_write_drive,
	input  wire logic [core_mem_pkg::WORD_W-1:0] i_inhibit,
	output logic      [core_mem_pkg::WORD_W-1:0] o_sense_data
);
	logic [WORD_W-1:0] mem [WORDS];

	// sense amps see the word while read current flows
	assign o_sense_data = i_read_drive ? mem[i_addr] : '0;

	// read current at the sense strobe flips every core to zero; write sets only uninhibited bits
	always_ff @(posedge i_clk_sys) begin
		if (i_read_drive && i_sense) begin
			mem[i_addr] <= '0; // RULE9
		end else if (i_write_drive) begin
			mem[i_addr] <= mem[i_addr] | ~i_inhibit; // RULE16
		end
	end
endmodule // core_stack

// >>> design/core_memory_cycle_control.sv
// core memory cycle control: pulse counter, self-timed phase chain, registers
`timescale 1ns/1ps
module core_memory_cycle_control (
	input  wire logic                                  i_clk_sys,
	input  wire logic                                  i_reset_n,
	input  wire logic                                  i_sys_pulse,
	input  wire logic                                  i_cycle_start_pulse,
	input  wire logic                                  i_write_req_level,
	input  wire logic                                  i_clock_normal_n,
	input  wire logic [core_mem_pkg::ADDR_W-1:0]       i_addr_in,
	input  wire logic [core_mem_pkg::DATA_W-1:0]       i_wr_data_in,
	input  wire logic [core_mem_pkg::AV_ADDR_W-1:0]    i_avs_address,
	input  wire logic                                  i_avs_read,
	input  wire logic                                  i_avs_write,
	input  wire logic [core_mem_pkg::AV_DATA_W-1:0]    i_avs_writedata,
	input  wire logic [core_mem_pkg::AV_BE_W-1:0]      i_avs_byteenable,
	output logic      [core_mem_pkg::AV_DATA_W-1:0]    o_avs_readdata,
	output logic                                       o_avs_waitrequest,
	output logic      [core_mem_pkg::DATA_W-1:0]       o_rd_data,
	output logic                                       o_cycle_done_n,
	output logic                                       o_read_gate_level,
	output logic                                       o_read_obtained_cpu,
	output logic                                       o_read_obtained_io_n,
	output logic                                       o_parity_err_flag
);
	import core_mem_pkg::*;

	//--------------------------------------------------------------
	// input synchronisers
	//--------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	logic [SYNC_W-1:0] stable_reg;
	logic [SYNC_W-1:0] stable_next;
	logic              pulse_prev_reg;
	logic              pulse_evt;
	logic              start_lvl;
	logic              write_lvl;
	logic              step_mode;

	// three stages; a change counts only once stages two and three agree
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {i_sys_pulse, i_cycle_start_pulse, i_write_req_level,
				i_clock_normal_n, i_addr_in, i_wr_data_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign stable_next = (~(sync2_reg ^ sync3_reg) & sync3_reg)
		| ((sync2_reg ^ sync3_reg) & stable_reg);

	// filtered levels and the system clock edge detector
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stable_reg     <= '0;
			pulse_prev_reg <= 1'b0;
		end else begin
			stable_reg     <= stable_next;
			pulse_prev_reg <= stable_reg[SY_PULSE];
		end
	end

	assign pulse_evt = stable_reg[SY_PULSE] & ~pulse_prev_reg;
	assign start_lvl = stable_reg[SY_START];
	assign write_lvl = stable_reg[SY_WRITE]; // RULE2
	assign step_mode = stable_reg[SY_NORM_N]; // RULE3

	//--------------------------------------------------------------
	// pulse counter and cycle start
	//--------------------------------------------------------------
	logic [1:0]        pcnt_reg;
	phase_type         phase_reg;
	logic              start_fire;
	logic              input_strobe;

	// a start while the chain is still busy is ignored; the counter stays at zero
	assign start_fire   = pulse_evt && pcnt_reg == PC_ZERO && start_lvl
		&& phase_reg == PH_IDLE; // RULE7
	assign input_strobe = start_fire && write_lvl; // RULE12

	// counter steps once per system clock pulse; at zero it steps only on a cycle start
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pcnt_reg <= PC_ZERO;
		end else if (pulse_evt) begin
			unique case (pcnt_reg)
				PC_ZERO:  pcnt_reg <= start_fire ? PC_ONE : PC_ZERO; // RULE6
				PC_ONE:   pcnt_reg <= PC_TWO; // RULE14
				PC_TWO:   pcnt_reg <= PC_THREE; // RULE17
				PC_THREE: pcnt_reg <= PC_ZERO; // RULE24
			endcase
		end
	end

	//--------------------------------------------------------------
	// timing configuration and self-timed phase chain
	//--------------------------------------------------------------
	logic [CNT_W-1:0] cfg_reg [NUM_CFG];
	logic [CNT_W-1:0] ph_cnt_reg;
	logic [CNT_W-1:0] ph_cnt_inc;
	logic             read_strobe;
	logic             write_phase_timer;
	logic             clear_timer;
	logic             read_phase_timer;
	logic             switch_timer;
	logic             av_wr_ok;

	assign ph_cnt_inc        = ph_cnt_reg + 1'b1;
	assign switch_timer      = phase_reg != PH_IDLE; // RULE7
	assign read_phase_timer  = phase_reg == PH_READ && switch_timer; // RULE9
	assign read_strobe       = read_phase_timer
		&& ph_cnt_reg == cfg_reg[CFG_STROBE]; // RULE26
	assign write_phase_timer = phase_reg == PH_INHIBIT
		&& ph_cnt_reg < cfg_reg[CFG_WRITE]; // RULE15
	assign clear_timer       = phase_reg == PH_CLEAR && ph_cnt_reg == '0; // RULE19

	// chain never looks at the system clock once started; zero counts act as one
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_reg  <= PH_IDLE;
			ph_cnt_reg <= '0;
		end else begin
			ph_cnt_reg <= ph_cnt_inc;
			unique case (phase_reg)
				PH_IDLE: begin
					ph_cnt_reg <= '0;
					if (start_fire) begin
						phase_reg <= PH_READ; // RULE8
					end
				end
				PH_READ: begin
					if (ph_cnt_inc >= cfg_reg[CFG_READ]) begin
						phase_reg  <= PH_GAP; // RULE15
						ph_cnt_reg <= '0;
					end
				end
				PH_GAP: begin
					if (ph_cnt_inc >= cfg_reg[CFG_GAP]) begin
						phase_reg  <= PH_INHIBIT; // RULE15
						ph_cnt_reg <= '0;
					end
				end
				PH_INHIBIT: begin
					// write phase holds inhibit over until it has ended too
					if (ph_cnt_inc >= cfg_reg[CFG_INH]
						&& ph_cnt_inc >= cfg_reg[CFG_WRITE]) begin
						phase_reg  <= PH_CLEAR; // RULE19
						ph_cnt_reg <= '0;
					end
				end
				PH_CLEAR: begin
					if (ph_cnt_inc >= cfg_reg[CFG_CLEAR]) begin
						phase_reg  <= PH_IDLE;
						ph_cnt_reg <= '0;
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// address, information register and write flag
	//--------------------------------------------------------------
	logic [ADDR_W-1:0] addr_reg;
	logic [WORD_W-1:0] info_register;
	logic [WORD_W-1:0] sense_data;
	logic [WORD_W-1:0] inhibit_reg;
	logic              write_op_flag;
	logic              step_clear;
	logic              strobe_done_reg;
	logic              parity_bad;

	// with the clock stepped, the end pulse clears too since the chain may lag
	assign step_clear = pulse_evt && pcnt_reg == PC_THREE && step_mode; // RULE3
	assign parity_bad = ~^info_register; // RULE13

	// address register
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr_reg <= '0;
		end else if (clear_timer || step_clear) begin
			addr_reg <= '0; // RULE19
		end else if (start_fire) begin
			addr_reg <= stable_reg[DATA_W +: ADDR_W]; // RULE1
		end
	end

	// write flag follows the input strobe only
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			write_op_flag <= 1'b0;
		end else if (clear_timer || step_clear) begin
			write_op_flag <= 1'b0; // RULE19
		end else if (input_strobe) begin
			write_op_flag <= 1'b1; // RULE4
		end
	end

	// information register: write data at start, sense data or parity at strobe
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			info_register <= '0;
		end else if (clear_timer || step_clear) begin
			info_register <= '0; // RULE19
		end else if (input_strobe) begin
			info_register <= {1'b0, stable_reg[DATA_W-1:0]}; // RULE4
		end else if (read_strobe && write_op_flag) begin
			info_register[WORD_W-1] <= ~^info_register[DATA_W-1:0]; // RULE10
		end else if (read_strobe) begin
			info_register <= sense_data; // RULE11
		end
	end

	// remembers that the strobe came, so parity is judged on sensed data
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strobe_done_reg <= 1'b0;
		end else if (start_fire) begin
			strobe_done_reg <= 1'b0;
		end else if (read_strobe) begin
			strobe_done_reg <= 1'b1; // RULE26
		end
	end

	// inhibit drivers: loaded from the gap on, so no write cycle goes uninhibited
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			inhibit_reg <= '0;
		end else if (phase_reg == PH_GAP || phase_reg == PH_INHIBIT) begin
			inhibit_reg <= ~info_register; // RULE16
		end else begin
			inhibit_reg <= '0;
		end
	end

	core_stack u_stack (
		.i_clk_sys     (i_clk_sys),
		.i_addr        (addr_reg),
		.i_read_drive  (read_phase_timer),
		.i_sense       (read_strobe),
		.i_write_drive (write_phase_timer && phase_reg == PH_INHIBIT),
		.i_inhibit     (inhibit_reg),
		.o_sense_data  (sense_data)
	);

	//--------------------------------------------------------------
	// levels to central control
	//--------------------------------------------------------------
	logic [CNT_W-1:0] err_count_reg;
	logic [CNT_W-1:0] cycle_count_reg;
	logic             err_set;

	assign err_set = pulse_evt && pcnt_reg == PC_TWO && !write_op_flag
		&& strobe_done_reg && parity_bad; // RULE13

	// error flag: set at third pulse, cleared unconditionally at fourth
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_parity_err_flag <= 1'b0;
		end else if (err_set) begin
			o_parity_err_flag <= 1'b1; // RULE20
		end else if (pulse_evt && pcnt_reg == PC_THREE) begin
			o_parity_err_flag <= 1'b0; // RULE24
		end
	end

	// timing levels decode the counter one fast cycle late
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cycle_done_n       <= 1'b1;
			o_read_obtained_cpu  <= 1'b0;
			o_read_obtained_io_n <= 1'b1;
			o_read_gate_level    <= 1'b0;
			o_rd_data            <= '0;
		end else begin
			o_cycle_done_n       <= pcnt_reg != PC_THREE; // RULE17
			o_read_obtained_cpu  <= pcnt_reg == PC_ONE && !write_op_flag; // RULE22
			o_read_obtained_io_n <= !(pcnt_reg == PC_ONE && !write_op_flag); // RULE22
			o_read_gate_level    <= pcnt_reg == PC_TWO && !write_op_flag; // RULE23
			o_rd_data            <= info_register[DATA_W-1:0]; // RULE5
		end
	end

	// statistics counters, wrap silently
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			err_count_reg   <= '0;
			cycle_count_reg <= '0;
		end else begin
			if (err_set) begin
				err_count_reg <= err_count_reg + 1'b1;
			end
			if (pulse_evt && pcnt_reg == PC_THREE) begin
				cycle_count_reg <= cycle_count_reg + 1'b1;
			end
		end
	end

	//--------------------------------------------------------------
	// avalon-mm slave
	//--------------------------------------------------------------
	logic [AV_DATA_W-1:0] rd_mux;
	logic [AV_DATA_W-1:0] status_word;

	// one wait state: the answer lands on the second edge of a request
	assign av_wr_ok = i_avs_write && !o_avs_waitrequest;

	always_comb begin
		status_word = '0;
		status_word[ST_PCNT_LSB +: 2]  = pcnt_reg;
		status_word[ST_PHASE_LSB +: 3] = phase_reg;
		status_word[ST_WRITE_BIT]      = write_op_flag;
		status_word[ST_ERR_BIT]        = o_parity_err_flag;
		status_word[ST_BUSY_BIT]       = switch_timer;
	end

	// unmapped offsets read zero
	always_comb begin
		rd_mux = '0;
		if (i_avs_address == REG_STATUS) begin
			rd_mux = status_word;
		end else if (i_avs_address == REG_ERR_COUNT) begin
			rd_mux = {{(AV_DATA_W-CNT_W){1'b0}}, err_count_reg};
		end else if (i_avs_address == REG_CYCLE_COUNT) begin
			rd_mux = {{(AV_DATA_W-CNT_W){1'b0}}, cycle_count_reg};
		end
		for (int k = 0; k < NUM_CFG; k++) begin
			if (i_avs_address == AV_ADDR_W'(REG_CFG_BASE + k * REG_STRIDE)) begin
				rd_mux = {{(AV_DATA_W-CNT_W){1'b0}}, cfg_reg[k]};
			end
		end
	end

	// handshake and read data capture
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= '0;
		end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b0;
			o_avs_readdata    <= rd_mux;
		end else begin
			o_avs_waitrequest <= 1'b1;
		end
	end

	// timing slots honour byte lanes 0 and 1; upper lanes have no storage
	generate
		for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
			always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
				if (!i_reset_n) begin
					cfg_reg[g] <= CFG_RESET[g];
				end else if (av_wr_ok && i_avs_address
					== AV_ADDR_W'(REG_CFG_BASE + g * REG_STRIDE)) begin
					for (int b = 0; b < CNT_W / BYTE_W; b++) begin
						if (i_avs_byteenable[b]) begin
							cfg_reg[g][b*BYTE_W +: BYTE_W]
								<= i_avs_writedata[b*BYTE_W +: BYTE_W]; // RULE25
						end
					end
				end
			end
		end
	endgenerate
endmodule // core_memory_cycle_control

// >>> sim/core_mem_sva.sv
// port assertions for the core memory cycle control
`timescale 1ns/1ps
module core_mem_sva (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic o_cycle_done_n,
	input wire logic o_read_gate_level,
	input wire logic o_read_obtained_cpu,
	input wire logic o_read_obtained_io_n,
	input wire logic o_parity_err_flag
);
	// one system pulse is 40 fast cycles; slack covers the pin synchroniser
	localparam int P_LO = 36;
	localparam int P_HI = 44;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// ----------------------------------------
	// register bus handshake
	// ----------------------------------------
	bus_answer_a: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus request not answered next cycle");
	wait_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	// ----------------------------------------
	// memory link levels
	// ----------------------------------------
	obtained_gate_a: assert property (
		$rose(o_read_obtained_cpu) |-> ##[P_LO:P_HI] $rose(o_read_gate_level))
		else $error("read gate not one pulse after obtained level");
	gate_done_a: assert property (
		$rose(o_read_gate_level) |-> ##[P_LO:P_HI] $fell(o_cycle_done_n))
		else $error("cycle done not one pulse after read gate");
	done_hold_a: assert property ($fell(o_cycle_done_n) |=> !o_cycle_done_n [*8])
		else $error("cycle done low too briefly");
	done_end_a: assert property (
		$fell(o_cycle_done_n) |-> ##[P_LO:P_HI] $rose(o_cycle_done_n))
		else $error("cycle done not released after one pulse");
	levels_apart_a: assert property (
		!o_cycle_done_n |-> !o_read_obtained_cpu && !o_read_gate_level)
		else $error("read level high during count three");
	io_inverse_a: assert property (o_read_obtained_io_n == !o_read_obtained_cpu)
		else $error("io obtained level not inverse of cpu level");
	err_set_a: assert property ($rose(o_parity_err_flag) |-> ##[0:2] !o_cycle_done_n)
		else $error("error flag set outside third pulse");
	err_clear_a: assert property ($rose(o_cycle_done_n) |-> !o_parity_err_flag)
		else $error("error flag not cleared at count zero");
	cover property ($rose(o_read_gate_level));
	cover property ($fell(o_cycle_done_n) && !o_read_gate_level);
	cover property (!o_avs_waitrequest && i_avs_write);
endmodule // core_mem_sva

bind core_memory_cycle_control core_mem_sva sva_u (.i_clk_sys, .i_reset_n, .i_avs_read,
	.i_avs_write, .o_avs_waitrequest, .o_cycle_done_n, .o_read_gate_level,
	.o_read_obtained_cpu, .o_read_obtained_io_n, .o_parity_err_flag);

// >>> sim/cc_model.sv
// central control model: system clock, cycle requests and link observation
`timescale 1ns/1ps
module cc_model (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_reset_n,
	input  wire logic [core_mem_pkg::DATA_W-1:0] i_rd_data,
	input  wire logic                           i_done_n,
	input  wire logic                           i_gate,
	input  wire logic                           i_cpu,
	input  wire logic                           i_err,
	output logic                                o_sys_pulse,
	output logic                                o_start,
	output logic                                o_write,
	output logic                                o_norm_n,
	output logic      [core_mem_pkg::ADDR_W-1:0] o_addr,
	output logic      [core_mem_pkg::DATA_W-1:0] o_data
);
	import core_mem_pkg::*;
	logic [5:0]        ph_reg;
	logic [DATA_W-1:0] rd_early, rd_late, got;
	logic              seen_cpu, seen_gate, seen_err, xpoint_reg;
	logic [31:0]       done_cnt;
	// free running 1 us system clock, high for the first half
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ph_reg <= 6'h00;
		end else begin
			ph_reg <= (ph_reg == 6'h27) ? 6'h00 : ph_reg + 6'h01;
		end
	end
	assign o_sys_pulse = (ph_reg < 6'h14);
	// clock switch starts normal; bench later steps it
	initial begin
		o_norm_n = 1'b0;
		{o_start, o_write, o_addr, o_data} = '0;
		xpoint_reg = 1'b0;
	end
	// one granted access: lines set as the low phase begins, held past the pulse edge
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		{seen_cpu, seen_gate, seen_err} = 3'h0;
		done_cnt = '0;
		got = '0;
		while (ph_reg != 6'h14) @(posedge i_clk_sys);
		xpoint_reg = 1'b1;
		o_start <= 1'b1;
		o_write <= wr;
		o_addr <= a;
		o_data <= d;
		repeat (30) @(posedge i_clk_sys);
		rd_early = i_rd_data;
		// released address and data lines show a changed value, never the held one
		o_start <= 1'b0;
		o_write <= 1'b0;
		o_addr <= ~a;
		o_data <= ~d;
		for (int i = 0; i < 200; i++) begin
			@(posedge i_clk_sys);
			if (i_cpu === 1'b1) seen_cpu = 1'b1;
			if (i_err === 1'b1) seen_err = 1'b1;
			if (i_done_n === 1'b0) done_cnt++;
			if (i_gate === 1'b1) begin
				seen_gate = 1'b1;
				got = i_rd_data;
			end
			if (ph_reg == 6'h00 && i_done_n === 1'b0) xpoint_reg = 1'b0;
		end
		rd_late = i_rd_data;
	endtask
endmodule // cc_model

// >>> sim/core_memory_cycle_control_bench.sv
// self-checking bench for the core memory cycle control
`timescale 1ns/1ps
module core_memory_cycle_control_bench;
	import core_mem_pkg::*;
	logic                 i_clk_sys, i_reset_n, av_rd, av_wr;
	logic [AV_ADDR_W-1:0] av_addr;
	logic [AV_DATA_W-1:0] av_wd;
	logic [AV_BE_W-1:0]   av_be;
	wire logic            pulse, start, wr_lvl, norm_n, waitreq, done_n, gate, cpu, io_n, err;
	wire logic [ADDR_W-1:0] addr;
	wire logic [DATA_W-1:0] wdata, rd_data;
	wire logic [AV_DATA_W-1:0] av_q;
	int                   errors, compares, ncyc, tick;
	logic [31:0]          dflt [6] = '{32'h0000_0028, 32'h0000_000c, 32'h0000_003e,
		32'h0000_0028, 32'h0000_001a, 32'h0000_0004};

	core_memory_cycle_control dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_sys_pulse(pulse), .i_cycle_start_pulse(start), .i_write_req_level(wr_lvl),
		.i_clock_normal_n(norm_n), .i_addr_in(addr), .i_wr_data_in(wdata),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .i_avs_byteenable(av_be), .o_avs_readdata(av_q),
		.o_avs_waitrequest(waitreq), .o_rd_data(rd_data), .o_cycle_done_n(done_n),
		.o_read_gate_level(gate), .o_read_obtained_cpu(cpu),
		.o_read_obtained_io_n(io_n), .o_parity_err_flag(err));
	cc_model cc_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_rd_data(rd_data),
		.i_done_n(done_n), .i_gate(gate), .i_cpu(cpu), .i_err(err), .o_sys_pulse(pulse),
		.o_start(start), .o_write(wr_lvl), .o_norm_n(norm_n), .o_addr(addr),
		.o_data(wdata));
	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic chk_d(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_r(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one bus access; waits for waitrequest low, the timeout bounds a hang
	task automatic av(input logic w, input logic [AV_ADDR_W-1:0] a,
			input logic [AV_DATA_W-1:0] d, output logic [AV_DATA_W-1:0] q);
		av_addr <= a;
		av_wd <= d;
		av_wr <= w;
		av_rd <= !w;
		do @(posedge i_clk_sys); while (waitreq !== 1'b0);
		q = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	// one memory cycle judged at the link
	task automatic cyc(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		cc_u.access(wr, a, d);
		ncyc++;
		chk_d(cc_u.rd_early, wr ? d : '0);
		chk_b(cc_u.seen_cpu, !wr);
		chk_b(cc_u.seen_gate, !wr);
		chk_b(cc_u.seen_err, 1'b0);
		chk_r(cc_u.done_cnt, 32'h0000_0028);
		chk_d(cc_u.rd_late, '0);
		chk_b(cc_u.xpoint_reg, 1'b0);
		if (!wr) chk_d(cc_u.got, d);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [31:0] q;
		for (int i = 0; i < 6; i++) begin
			av(1'b0, AV_ADDR_W'(4 + 4 * i), '0, q);
			chk_r(q, dflt[i]);
		end
		av(1'b1, 6'h08, 32'h0000_0010, q);
		av(1'b0, 6'h08, '0, q);
		chk_r(q, 32'h0000_0010);
		av(1'b1, 6'h08, 32'h0000_000c, q);
		av(1'b1, 6'h00, 32'hffff_ffff, q);
		av(1'b0, 6'h00, '0, q);
		chk_r(q, '0);
		av(1'b1, 6'h3c, 32'hffff_ffff, q);
		av(1'b0, 6'h3c, '0, q);
		chk_r(q, '0);
	endtask
	// extremes of data; all zeros needs the parity bit set to read back clean
	task automatic t_patterns;
		logic [ADDR_W-1:0] a [3] = '{12'hfff, 12'h000, 12'h5a5};
		logic [DATA_W-1:0] d [3] = '{48'hffff_ffff_ffff, 48'h0000_0000_0000,
			48'ha5a5_5a5a_0f0f};
		for (int i = 0; i < 3; i++) begin
			cyc(1'b1, a[i], d[i]);
			cyc(1'b0, a[i], d[i]);
			cyc(1'b0, a[i], d[i]);
		end
	endtask
	task automatic t_addr_sep;
		cc_u.o_norm_n <= 1'b1;
		cyc(1'b1, 12'h001, 48'h1234_5678_9abc);
		cyc(1'b1, 12'h800, 48'hedcb_a987_6543);
		cyc(1'b0, 12'h001, 48'h1234_5678_9abc);
		cyc(1'b0, 12'h800, 48'hedcb_a987_6543);
	endtask
	// late strobe skips clear and parity bit; read then sees even ones
	task automatic t_counts;
		logic [31:0] q;
		av(1'b1, 6'h14, 32'h0000_0030, q);
		cc_u.access(1'b1, '0, 48'h1);
		av(1'b1, 6'h14, 32'h0000_001a, q);
		cc_u.access(1'b0, '0, '0);
		chk_b(cc_u.seen_err, 1'b1);
		av(1'b1, 6'h20, 32'h0000_00ff, q);
		av(1'b0, 6'h20, '0, q);
		chk_r(q, 32'(ncyc + 2));
		av(1'b0, 6'h1c, '0, q);
		chk_r(q, 32'h0000_0001);
		av(1'b0, 6'h00, '0, q);
		chk_r(q, '0);
	endtask
	// ----------------------------------------
	// clock, reset, sequence and verdict
	// ----------------------------------------
	task automatic final_report;
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	// ceiling sits well above the roughly 3700 cycles the sequence needs
	always @(posedge i_clk_sys) begin
		tick++;
		if (tick == 12000) begin
			errors++;
			final_report;
		end
	end
	initial begin
		{errors, compares, ncyc, tick} = '0;
		{av_rd, av_wr, av_addr, av_wd} = '0;
		av_be = 4'hf;
		i_reset_n = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		@(posedge i_clk_sys);
		t_regs;
		t_patterns;
		t_addr_sep;
		t_counts;
		final_report;
	end
endmodule // core_memory_cycle_control_bench
